// ==== src/mpf_pkg.sv ====
/*
 Constants, register word numbers and carrier types for the serial port
 poll sequencer and frame gap detector.
 Assumes a 125 MHz clock and 16-bit database words.
*/
package mpf_pkg;
   // -----------------------------------------------------------------
   // Timing
   // -----------------------------------------------------------------
   localparam int CLK_NS    = 8;
   localparam int MS_NS     = 1000000;
   localparam int MS_CYCLES = (MS_NS + CLK_NS - 1) / CLK_NS;

   // -----------------------------------------------------------------
   // Database word numbers
   // -----------------------------------------------------------------
   localparam logic [12:0] A_PROTOCOL  = 13'h13B5;
   localparam logic [12:0] A_BAUD      = 13'h13B6;
   localparam logic [12:0] A_CMD_COUNT = 13'h13C3;
   localparam logic [12:0] A_PAUSE     = 13'h13C4;
   localparam logic [12:0] A_ERR_LOC   = 13'h13C5;
   localparam logic [12:0] A_WAIT_LIM  = 13'h13C6;
   localparam logic [12:0] A_RETRY     = 13'h13C7;
   localparam logic [12:0] A_SUSPEND   = 13'h13C8;
   localparam logic [12:0] A_GAP       = 13'h13CD;
   localparam logic [12:0] A_CMD_FIRST = 13'h1900;
   localparam logic [12:0] A_CMD_2ND   = 13'h190A;
   localparam logic [12:0] A_CMD_LAST  = 13'h1CDE;
   localparam logic [12:0] A_CTL_CODE  = 13'h1E78;

   // -----------------------------------------------------------------
   // Command table layout
   // -----------------------------------------------------------------
   localparam int          NUM_CMDS   = 100;
   localparam int          CMD_WORDS  = 8;
   localparam logic [12:0] CMD_STRIDE = 13'h000A;
   localparam int          TBL_WORDS  = NUM_CMDS * CMD_WORDS;
   localparam logic [2:0]  W_ENABLE   = 3'h0;
   localparam logic [2:0]  W_SLAVE    = 3'h1;

   // -----------------------------------------------------------------
   // Codes and values
   // -----------------------------------------------------------------
   localparam logic [15:0] CTL_LIST   = 16'h270D;
   localparam logic [15:0] CTL_WARM   = 16'h270E;
   localparam logic [15:0] CTL_COLD   = 16'h270F;
   localparam logic [15:0] ERR_NONE   = 16'h0000;
   localparam logic [15:0] ERR_TMO    = 16'hFFF5;
   localparam logic [15:0] LOC_OFF    = 16'hFFFF;
   localparam logic [15:0] LOC_MAX    = 16'h1387;
   localparam logic [15:0] PROTO_RTU  = 16'h0000;
   localparam logic [15:0] PROTO_ASC  = 16'h0001;

   // Baud codes as entered, and the built-in gap in milliseconds.
   localparam logic [15:0] B_110   = 16'h006E;
   localparam logic [15:0] B_150   = 16'h0096;
   localparam logic [15:0] B_300   = 16'h012C;
   localparam logic [15:0] B_600   = 16'h0258;
   localparam logic [15:0] B_1200  = 16'h04B0;
   localparam logic [15:0] B_2400  = 16'h0960;
   localparam logic [15:0] B_4800  = 16'h12C0;
   localparam logic [15:0] B_9600  = 16'h2580;
   localparam logic [15:0] B_19200 = 16'h4B00;
   localparam logic [15:0] B_28800 = 16'h7080;
   localparam logic [15:0] B_38400 = 16'h0180;
   localparam logic [15:0] B_57600 = 16'h0240;
   localparam logic [15:0] B_115K  = 16'h0073;
   localparam logic [15:0] G_110   = 16'h015E;
   localparam logic [15:0] G_150   = 16'h0100;
   localparam logic [15:0] G_300   = 16'h0080;
   localparam logic [15:0] G_600   = 16'h0040;
   localparam logic [15:0] G_1200  = 16'h0020;
   localparam logic [15:0] G_2400  = 16'h0010;
   localparam logic [15:0] G_4800  = 16'h0008;
   localparam logic [15:0] G_9600  = 16'h0004;
   localparam logic [15:0] G_MID   = 16'h0002;
   localparam logic [15:0] G_FAST  = 16'h0001;
   localparam logic [15:0] G_OTHER = 16'h0002;

   // -----------------------------------------------------------------
   // Types
   // -----------------------------------------------------------------
   typedef struct packed {
      logic [12:0] addr;
      logic [15:0] code;
   } mpf_err_type;

   typedef struct packed {
      logic [6:0] idx;
      logic [7:0] slave;
   } mpf_cmd_type;

   typedef enum logic [2:0] {
      ST_IDLE   = 3'b000,
      ST_CHECK  = 3'b001,
      ST_PAUSE  = 3'b010,
      ST_SEND   = 3'b011,
      ST_WAIT   = 3'b100,
      ST_REPORT = 3'b101,
      ST_NEXT   = 3'b110
   } mpf_state_type;
endpackage : mpf_pkg

// ==== src/mpf_buf2.sv ====
/*
 Two-entry buffer for error report words.
 Assumes one clock; the output side may stall at any time.
*/
`timescale 1ns/1ps
module mpf_buf2
   import mpf_pkg::*;
(
   // Clock and reset
   input  wire logic        clk_i,
   input  wire logic        rstn_i,
   // Filling side
   input  wire logic        in_valid_i,
   input  wire mpf_err_type in_data_i,
   output logic             in_ready_o,
   // Draining side
   output logic             out_valid_o,
   output mpf_err_type      out_data_o,
   input  wire logic        out_ready_i
);
   mpf_err_type spare_q;
   logic        spare_v_q;
   logic        push;
   logic        pop;

   assign push = in_valid_i && in_ready_o;
   assign pop  = out_valid_o && out_ready_i;

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         out_valid_o <= 1'b0;
         out_data_o  <= '0;
         spare_v_q   <= 1'b0;
         spare_q     <= '0;
      end else begin
         if (pop || !out_valid_o) begin
            if (spare_v_q) begin
               out_data_o <= spare_q;
               spare_v_q  <= push;
               spare_q    <= in_data_i;
            end else begin
               out_valid_o <= push;
               out_data_o  <= in_data_i;
            end
         end else if (push) begin
            spare_v_q <= 1'b1;
            spare_q   <= in_data_i;
         end
      end
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         in_ready_o <= 1'b0;
      end else begin
         in_ready_o <= !(spare_v_q || (push && out_valid_o && !pop));
      end
   end
endmodule : mpf_buf2

// ==== src/mpf_port.sv ====
/*
 Serial port poll sequencer with response timeout, retries, slave
 suspension and error reports, plus the receive frame gap detector.
 Assumes synchronous inputs, a single 125 MHz clock and that the
 framing logic pulses rx_byte_i once per received byte.
*/
`timescale 1ns/1ps
// Functional notes
// - Wait the inter-command pause before each new command, never before retries.
// - Write each command's error code to the chosen word; minus one disables.
// - Count reply wait in milliseconds and resend when it expires unanswered.
// - Retry up to the limit, then suspend the silent slave.
// - Skip a suspended slave's commands for the set polls, then try again.
// - Gap setting zero uses the baud table, else gives milliseconds directly.
// - Gap timing only in RTU framing as slave on multidrop.
// - A 3.5 character silence ends a message; next byte starts one.
// - Built-in gaps: 110 gives 350 ms down to 115200 gives 1 ms.
// - Hold 100 command entries of eight words, ten words apart.
// - Control codes 9997 to 9999 in word 7800 restart the module.
// - Framing value zero selects RTU, one selects ASCII.
// - A command that never gets a reply reports code minus eleven.
module mpf_port
   import mpf_pkg::*;
#(
   parameter int MS_DIV = MS_CYCLES
)(
   // Clock and reset
   input  wire logic         clk_i,
   input  wire logic         rstn_i,
   // Database word port
   input  wire logic         db_wr_i,
   input  wire logic         db_rd_i,
   input  wire logic [12:0]  db_addr_i,
   input  wire logic [15:0]  db_wdata_i,
   output logic [15:0]       db_rdata_o,
   // Port role
   input  wire logic         master_i,
   input  wire logic         multidrop_i,
   // Command issue and reply
   output logic              cmd_valid_o,
   output mpf_cmd_type       cmd_o,
   input  wire logic         reply_i,
   input  wire logic [15:0]  reply_code_i,
   // Receive byte events and message boundaries
   input  wire logic         rx_byte_i,
   output logic              msg_start_o,
   output logic              msg_end_o,
   // Error report words
   output logic              err_valid_o,
   output mpf_err_type       err_o,
   input  wire logic         err_ready_i
);
   // -----------------------------------------------------------------
   // Millisecond tick
   // -----------------------------------------------------------------
   logic [16:0] div_q;
   logic        ms_tick;

   assign ms_tick = (div_q == 17'(MS_DIV - 1));

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) div_q <= '0;
      else div_q <= ms_tick ? '0 : div_q + 17'h00001;
   end

   // -----------------------------------------------------------------
   // Configuration and control registers
   // -----------------------------------------------------------------
   logic [15:0] proto_q, baud_q, ncmd_q, pause_q, loc_q;
   logic [15:0] wait_q, retry_q, susp_q, gap_q, ctl_q;
   logic        ctl_hit, ctl_clr_susp;
   logic [15:0] tbl [0:TBL_WORDS-1];
   logic [12:0] t_off;
   logic [6:0]  t_ent;
   logic [3:0]  t_wd;
   logic        in_tbl;
   logic [9:0]  t_idx;

   assign ctl_hit = db_wr_i && db_addr_i == A_CTL_CODE &&
                    (db_wdata_i == CTL_LIST || db_wdata_i == CTL_WARM ||
                     db_wdata_i == CTL_COLD);
   assign ctl_clr_susp = ctl_hit && db_wdata_i != CTL_LIST;
   assign t_off  = db_addr_i - A_CMD_FIRST;
   assign t_ent  = 7'(t_off / CMD_STRIDE);
   assign t_wd   = 4'(t_off - 13'(t_ent) * CMD_STRIDE);
   assign in_tbl = db_addr_i >= A_CMD_FIRST &&
                   db_addr_i <= A_CMD_LAST + 13'(CMD_WORDS - 1) &&
                   t_wd < 4'(CMD_WORDS);
   assign t_idx  = {t_ent, t_wd[2:0]};

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         {proto_q, baud_q, ncmd_q, pause_q, loc_q} <= '0;
         {wait_q, retry_q, susp_q, gap_q, ctl_q} <= '0;
      end else if (ctl_hit && db_wdata_i == CTL_COLD) begin
         {proto_q, baud_q, ncmd_q, pause_q, loc_q} <= '0;
         {wait_q, retry_q, susp_q, gap_q, ctl_q} <= '0;
      end else if (db_wr_i && !ctl_hit) begin
         case (db_addr_i)
            A_PROTOCOL:  proto_q <= db_wdata_i;
            A_BAUD:      baud_q  <= db_wdata_i;
            A_CMD_COUNT: ncmd_q  <= db_wdata_i;
            A_PAUSE:     pause_q <= db_wdata_i;
            A_ERR_LOC:   loc_q   <= db_wdata_i;
            A_WAIT_LIM:  wait_q  <= db_wdata_i;
            A_RETRY:     retry_q <= db_wdata_i;
            A_SUSPEND:   susp_q  <= db_wdata_i;
            A_GAP:       gap_q   <= db_wdata_i;
            A_CTL_CODE:  ctl_q   <= db_wdata_i;
            default:     ;
         endcase
      end else if (ctl_hit) begin
         ctl_q <= '0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (db_wr_i && in_tbl) tbl[t_idx] <= db_wdata_i;
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         db_rdata_o <= '0;
      end else if (db_rd_i) begin
         case (db_addr_i)
            A_PROTOCOL:  db_rdata_o <= proto_q;
            A_BAUD:      db_rdata_o <= baud_q;
            A_CMD_COUNT: db_rdata_o <= ncmd_q;
            A_PAUSE:     db_rdata_o <= pause_q;
            A_ERR_LOC:   db_rdata_o <= loc_q;
            A_WAIT_LIM:  db_rdata_o <= wait_q;
            A_RETRY:     db_rdata_o <= retry_q;
            A_SUSPEND:   db_rdata_o <= susp_q;
            A_GAP:       db_rdata_o <= gap_q;
            A_CTL_CODE:  db_rdata_o <= ctl_q;
            default:     db_rdata_o <= in_tbl ? tbl[t_idx] : '0;
         endcase
      end
   end

   // -----------------------------------------------------------------
   // Poll sequencer
   // -----------------------------------------------------------------
   mpf_state_type st_q;
   logic [6:0]    idx_q;
   logic [15:0]   tmr_q, tries_q, res_q;
   logic [7:0]    slave_l;
   logic          en_l, run, loc_ok, buf_rdy, timeout, last_idx;
   logic          sv_l, rpt_push;
   logic [255:0]  susp_v_q;
   logic [15:0]   susp_cnt [0:255];
   logic [15:0]   ncmd_eff;

   assign en_l     = tbl[{idx_q, W_ENABLE}] != 16'h0000;
   assign slave_l  = tbl[{idx_q, W_SLAVE}][7:0];
   assign sv_l     = susp_v_q[slave_l];
   assign ncmd_eff = ncmd_q > 16'(NUM_CMDS) ? 16'(NUM_CMDS) : ncmd_q;
   assign run      = master_i && ncmd_eff != 16'h0000;
   assign last_idx = 16'(idx_q) + 16'h0001 >= ncmd_eff;
   assign loc_ok   = loc_q != LOC_OFF && loc_q <= LOC_MAX;
   assign timeout  = st_q == ST_WAIT && !reply_i && tmr_q >= wait_q;
   assign rpt_push = st_q == ST_REPORT && loc_ok;

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         st_q    <= ST_IDLE;
         idx_q   <= '0;
         tmr_q   <= '0;
         tries_q <= '0;
         res_q   <= ERR_NONE;
      end else if (ctl_hit || !run) begin
         st_q  <= ST_IDLE;
         idx_q <= '0;
      end else begin
         case (st_q)
            ST_IDLE: st_q <= ST_CHECK;
            ST_CHECK: begin
               tmr_q   <= '0;
               tries_q <= '0;
               if (!en_l || (sv_l && susp_cnt[slave_l] != 16'h0000))
                  st_q <= ST_NEXT;
               else
                  st_q <= ST_PAUSE;
            end
            ST_PAUSE: begin
               if (tmr_q >= pause_q) st_q <= ST_SEND;
               else if (ms_tick) tmr_q <= tmr_q + 16'h0001;
            end
            ST_SEND: begin
               tmr_q <= '0;
               st_q  <= ST_WAIT;
            end
            ST_WAIT: begin
               if (reply_i) begin
                  res_q <= reply_code_i;
                  st_q  <= ST_REPORT;
               end else if (timeout) begin
                  if (tries_q < retry_q) begin
                     tries_q <= tries_q + 16'h0001;
                     st_q    <= ST_SEND;
                  end else begin
                     res_q <= ERR_TMO;
                     st_q  <= ST_REPORT;
                  end
               end else if (ms_tick) begin
                  tmr_q <= tmr_q + 16'h0001;
               end
            end
            ST_REPORT: if (!loc_ok || buf_rdy) st_q <= ST_NEXT;
            ST_NEXT: begin
               idx_q <= last_idx ? '0 : idx_q + 7'h01;
               st_q  <= ST_CHECK;
            end
            default: st_q <= ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         susp_v_q <= '0;
      end else if (ctl_clr_susp) begin
         susp_v_q <= '0;
      end else if (timeout && tries_q >= retry_q && run) begin
         susp_v_q[slave_l] <= 1'b1;
      end else if (st_q == ST_CHECK && en_l && sv_l && run &&
                   susp_cnt[slave_l] == 16'h0000) begin
         susp_v_q[slave_l] <= 1'b0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (timeout && tries_q >= retry_q)
         susp_cnt[slave_l] <= susp_q;
      else if (st_q == ST_CHECK && en_l && sv_l &&
               susp_cnt[slave_l] != 16'h0000)
         susp_cnt[slave_l] <= susp_cnt[slave_l] - 16'h0001;
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         cmd_valid_o <= 1'b0;
         cmd_o       <= '0;
      end else begin
         cmd_valid_o <= st_q == ST_SEND && run && !ctl_hit;
         if (st_q == ST_SEND) cmd_o <= '{idx: idx_q, slave: slave_l};
      end
   end

   mpf_buf2 u_buf (
      .clk_i       (clk_i),
      .rstn_i      (rstn_i),
      .in_valid_i  (rpt_push),
      .in_data_i   ('{addr: loc_q[12:0], code: res_q}),
      .in_ready_o  (buf_rdy),
      .out_valid_o (err_valid_o),
      .out_data_o  (err_o),
      .out_ready_i (err_ready_i)
   );

   // -----------------------------------------------------------------
   // Receive frame gap detector
   // -----------------------------------------------------------------
   logic [15:0] gap_ms, gcnt_q;
   logic        gap_on, in_msg_q;

   assign gap_on = proto_q == PROTO_RTU && !master_i && multidrop_i;

   always_comb begin
      gap_ms = gap_q;
      if (gap_q == 16'h0000) begin
         case (baud_q)
            B_110:   gap_ms = G_110;
            B_150:   gap_ms = G_150;
            B_300:   gap_ms = G_300;
            B_600:   gap_ms = G_600;
            B_1200:  gap_ms = G_1200;
            B_2400:  gap_ms = G_2400;
            B_4800:  gap_ms = G_4800;
            B_9600:  gap_ms = G_9600;
            B_19200, B_28800, B_38400: gap_ms = G_MID;
            B_57600, B_115K: gap_ms = G_FAST;
            default: gap_ms = G_OTHER;
         endcase
      end
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         gcnt_q      <= '0;
         in_msg_q    <= 1'b0;
         msg_start_o <= 1'b0;
         msg_end_o   <= 1'b0;
      end else begin
         msg_start_o <= 1'b0;
         msg_end_o   <= 1'b0;
         if (!gap_on) begin
            in_msg_q <= 1'b0;
            gcnt_q   <= '0;
         end else if (rx_byte_i) begin
            gcnt_q      <= '0;
            in_msg_q    <= 1'b1;
            msg_start_o <= !in_msg_q;
         end else if (in_msg_q && ms_tick) begin
            if (gcnt_q + 16'h0001 >= gap_ms) begin
               in_msg_q  <= 1'b0;
               msg_end_o <= 1'b1;
               gcnt_q    <= '0;
            end else begin
               gcnt_q <= gcnt_q + 16'h0001;
            end
         end
      end
   end

   // -----------------------------------------------------------------
   // Assertions
   // -----------------------------------------------------------------
   sequence s_retry_due;
      timeout && tries_q < retry_q && run && !ctl_hit;
   endsequence

   sequence s_resend;
      st_q == ST_SEND ##1 cmd_valid_o;
   endsequence

   a_pause_before_send: assert property (@(posedge clk_i) disable iff (!rstn_i)
      (st_q == ST_PAUSE && run && !ctl_hit) ##1 st_q == ST_SEND
      |-> $past(tmr_q) >= pause_q)
      else $error("command sent before pause elapsed");

   a_retry_resend: assert property (@(posedge clk_i) disable iff (!rstn_i)
      s_retry_due |=> s_resend)
      else $error("retry not resent without pause");

   a_report_push: assert property (@(posedge clk_i) disable iff (!rstn_i)
      (rpt_push && buf_rdy && !err_valid_o) |=> err_valid_o &&
      err_o.code == $past(res_q))
      else $error("error report word not delivered");

   a_report_off: assert property (@(posedge clk_i) disable iff (!rstn_i)
      (st_q == ST_REPORT && !loc_ok && run && !ctl_hit)
      |=> st_q == ST_NEXT)
      else $error("report off stalled sequencer");

   a_suspend_set: assert property (@(posedge clk_i) disable iff (!rstn_i)
      (timeout && tries_q >= retry_q && run && !ctl_clr_susp)
      |=> susp_v_q[$past(slave_l)] && res_q == ERR_TMO)
      else $error("silent slave not suspended");

   a_skip_suspended: assert property (@(posedge clk_i) disable iff (!rstn_i)
      (st_q == ST_CHECK && run && !ctl_hit && en_l && sv_l &&
       susp_cnt[slave_l] != 16'h0000) |=> st_q == ST_NEXT ##1 !cmd_valid_o)
      else $error("suspended slave polled");

   a_gap_end: assert property (@(posedge clk_i) disable iff (!rstn_i)
      (gap_on && in_msg_q && ms_tick && !rx_byte_i &&
       gcnt_q + 16'h0001 >= gap_ms) |=> msg_end_o && !in_msg_q)
      else $error("message end missed after gap");

   a_gap_early: assert property (@(posedge clk_i) disable iff (!rstn_i)
      rx_byte_i |=> !msg_end_o)
      else $error("message ended right after a byte");

   a_gap_mode: assert property (@(posedge clk_i) disable iff (!rstn_i)
      !gap_on [*2] |-> !msg_end_o && !msg_start_o)
      else $error("gap timing outside its mode");

   a_gap_table: assert property (@(posedge clk_i) disable iff (!rstn_i)
      (gap_q == 16'h0000 && baud_q == B_9600) |-> gap_ms == G_9600)
      else $error("built-in gap wrong for 9600");

   a_ctl_restart: assert property (@(posedge clk_i) disable iff (!rstn_i)
      ctl_hit |=> st_q == ST_IDLE && idx_q == 7'h00 ##1 !cmd_valid_o)
      else $error("control code did not restart sequencer");

   a_tbl_store: assert property (@(posedge clk_i) disable iff (!rstn_i)
      (db_wr_i && in_tbl) ##1 (db_rd_i && !db_wr_i &&
       db_addr_i == $past(db_addr_i)) |=> db_rdata_o == $past(db_wdata_i, 2))
      else $error("command table word not stored");
endmodule : mpf_port

// ==== test/mpf_slave_model.sv ====
/*
 Network slave model that answers issued commands after a set lag.
 Assumes commands arrive as one-cycle pulses from the port.
*/
`timescale 1ns/1ps
module mpf_slave_model
   import mpf_pkg::*;
(
   // Clock and reset
   input  wire logic        clk_i,
   input  wire logic        rstn_i,
   // Command side
   input  wire logic        cmd_valid_i,
   input  wire mpf_cmd_type cmd_i,
   input  wire logic [7:0]  mute_i,
   input  wire logic [7:0]  lag_i,
   // Reply side
   output logic             reply_o,
   output logic [15:0]      reply_code_o
);
   logic [7:0] cnt_q;
   logic       busy_q;
   // A muted address never answers; the code wanders between replies.
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         {busy_q, cnt_q, reply_o, reply_code_o} <= '0;
      end else begin
         reply_o      <= 1'b0;
         reply_code_o <= ~reply_code_o;
         if (cmd_valid_i && cmd_i.slave != mute_i) begin
            busy_q <= 1'b1;
            cnt_q  <= lag_i;
         end else if (busy_q && cnt_q == 8'h00) begin
            busy_q       <= 1'b0;
            reply_o      <= 1'b1;
            reply_code_o <= ERR_NONE;
         end else if (busy_q) begin
            cnt_q <= cnt_q - 8'h01;
         end
      end
   end
endmodule : mpf_slave_model

// ==== test/tb_top.sv ====
/*
 Self-checking bench for the poll sequencer and gap detector.
 Assumes the slave model answers the command side.
*/
`timescale 1ns/1ps
module tb_top;
   import mpf_pkg::*;
   localparam int MD = 10;
   logic        clk_i = 0, rstn_i = 0, db_wr_i = 0, db_rd_i = 0;
   logic        master_i = 0, multidrop_i = 0, rx_byte_i = 0;
   logic        err_ready_i = 1, reply_i, cmd_valid_o, err_valid_o;
   logic        msg_start_o, msg_end_o;
   logic [12:0] db_addr_i = '0;
   logic [15:0] db_wdata_i = '0, db_rdata_o, reply_code_i, rdv;
   logic [7:0]  mute = '0, lag = 8'h03;
   mpf_cmd_type cmd_o;
   mpf_err_type err_o, errq[$];
   int          n_errors = 0, check_count = 0, cyc = 0, last = 0;
   int          mingap, run2, starts, ends, tmo, t2a, t2b, s, sends[256];
   int          gms[13] = '{350, 256, 128, 64, 32, 16, 8, 4, 2, 2, 2, 1, 1};
   logic [15:0] bds[13] = '{B_110, B_150, B_300, B_600, B_1200, B_2400,
      B_4800, B_9600, B_19200, B_28800, B_38400, B_57600, B_115K};
   mpf_port #(.MS_DIV(MD)) dut (.clk_i, .rstn_i, .db_wr_i, .db_rd_i,
      .db_addr_i, .db_wdata_i, .db_rdata_o, .master_i, .multidrop_i,
      .cmd_valid_o, .cmd_o, .reply_i, .reply_code_i, .rx_byte_i,
      .msg_start_o, .msg_end_o, .err_valid_o, .err_o, .err_ready_i);
   mpf_slave_model model (.clk_i, .rstn_i, .cmd_valid_i(cmd_valid_o),
      .cmd_i(cmd_o), .mute_i(mute), .lag_i(lag), .reply_o(reply_i),
      .reply_code_o(reply_code_i));
   initial forever #4 clk_i = ~clk_i;
   initial begin
      repeat (90000) @(posedge clk_i);
      n_errors++;
      end_of_test;
   end
   always @(posedge clk_i) begin
      cyc++;
      if (cmd_valid_o === 1'b1) begin
         sends[cmd_o.slave]++;
         run2 = (cmd_o.slave == 8'h02) ? run2 + 1 : 0;
         if (cmd_o.slave == 8'h02) {t2a, t2b} = {t2b, cyc};
         if (cyc - last < mingap) mingap = cyc - last;
         last = cyc;
      end
      if (err_valid_o === 1'b1 && err_ready_i) errq.push_back(err_o);
      if (err_valid_o === 1'b1 && err_ready_i && err_o.code === ERR_TMO) tmo++;
      starts += (msg_start_o === 1'b1);
      ends += (msg_end_o === 1'b1);
   end
   task chk(input bit ok, input string m);
      check_count++;
      if (!ok) begin
         n_errors++;
         $display("[FAIL] %0t %s", $time, m);
      end
   endtask : chk
   task wr(input logic [12:0] a, input logic [15:0] d);
      @(posedge clk_i);
      {db_wr_i, db_addr_i, db_wdata_i} <= {1'b1, a, d};
      @(posedge clk_i);
      db_wr_i <= 1'b0;
   endtask : wr
   task rd(input logic [12:0] a);
      @(posedge clk_i);
      {db_rd_i, db_addr_i} <= {1'b1, a};
      @(posedge clk_i);
      db_rd_i <= 1'b0;
      #1 rdv = db_rdata_o;
   endtask : rd
   task pulse;
      @(posedge clk_i);
      rx_byte_i <= 1'b1;
      @(posedge clk_i);
      rx_byte_i <= 1'b0;
   endtask : pulse
   task t_regs;
      rd(A_CMD_FIRST + 13'h0008);
      chk(rdv === 16'h0000, "gap word not unmapped");
      wr(A_CMD_LAST + 13'h0007, 16'h5A5A);
      rd(A_CMD_LAST + 13'h0007);
      chk(rdv === 16'h5A5A, "last entry word");
      wr(A_CMD_FIRST, 1);
      wr(A_CMD_FIRST + 13'h0001, 1);
      wr(A_CMD_2ND, 1);
      wr(A_CMD_2ND + 13'h0001, 2);
      wr(A_CMD_COUNT, 2);
      wr(A_PAUSE, 6);
      wr(A_ERR_LOC, 16'h0064);
      wr(A_WAIT_LIM, 2);
      wr(A_RETRY, 1);
      wr(A_SUSPEND, 2);
      rd(A_PAUSE);
      chk(rdv === 16'h0006, "pause readback");
      $display("regs done");
   endtask : t_regs
   task t_poll;
      mingap = 1000;
      master_i <= 1'b1;
      for (int i = 0; i < 3000 && errq.size() < 4; i++) @(posedge clk_i);
      chk(errq.size() >= 4, "too few reports");
      for (int i = 0; i < 4 && i < errq.size(); i++)
         chk(errq[i] === {13'h0064, ERR_NONE}, "report word");
      chk(mingap >= 5 * MD, "pause too short");
      $display("poll done");
   endtask : t_poll
   task t_timeout;
      mute = 8'h02;
      for (int i = 0; i < 4000 && tmo == 0; i++) @(posedge clk_i);
      chk(tmo > 0, "no timeout code");
      chk(run2 === 2, "retry count");
      chk(t2b - t2a >= MD && t2b - t2a < 4 * MD, "retry spacing");
      sends = '{default: 0};
      for (int i = 0; i < 3000 && sends[1] < 3; i++) @(posedge clk_i);
      chk(sends[1] === 3 && sends[2] === 0, "suspended slave polled");
      for (int i = 0; i < 3000 && sends[2] < 1; i++) @(posedge clk_i);
      chk(sends[2] === 1 && sends[1] === 3, "no resumption");
      mute = 8'h00;
      $display("timeout done");
   endtask : t_timeout
   task t_stall;
      err_ready_i <= 1'b0;
      repeat (600) @(posedge clk_i);
      s = sends[1] + sends[2];
      repeat (300) @(posedge clk_i);
      chk(sends[1] + sends[2] === s && err_valid_o === 1'b1, "no stall");
      errq.delete();
      err_ready_i <= 1'b1;
      repeat (100) @(posedge clk_i);
      chk(errq.size() >= 2, "buffer lost words");
      $display("stall done");
   endtask : t_stall
   task t_noloc;
      foreach (bds[k]) if (k < 2) begin
         wr(A_ERR_LOC, k == 0 ? LOC_OFF : 16'h1388);
         repeat (300) @(posedge clk_i);
         errq.delete();
         repeat (600) @(posedge clk_i);
         chk(errq.size() == 0, "report not suppressed");
      end
      wr(A_ERR_LOC, LOC_MAX);
      repeat (600) @(posedge clk_i);
      chk(errq.size() > 0 && errq[$].addr === 13'h1387, "top location");
      $display("location done");
   endtask : t_noloc
   task gap_run(input int g);
      int s0, e0;
      {s0, e0} = {starts, ends};
      pulse;
      if (g > 1) repeat ((g - 1) * MD - 2) @(posedge clk_i);
      if (g > 1) pulse;
      repeat ((g - 1) * MD - 1) @(posedge clk_i);
      chk(ends === e0, "early end");
      repeat (MD + 4) @(posedge clk_i);
      chk(ends === e0 + 1 && starts === s0 + 1, "boundary");
   endtask : gap_run
   task gap_off;
      {s, last} = {starts, ends};
      pulse;
      repeat (100) @(posedge clk_i);
      chk(starts === s && ends === last, "gap outside mode");
   endtask : gap_off
   task t_gap;
      {master_i, multidrop_i} <= 2'b01;
      wr(A_GAP, 3);
      gap_run(3);
      wr(A_GAP, 0);
      foreach (bds[k]) begin
         wr(A_BAUD, bds[k]);
         gap_run(gms[k]);
      end
      wr(A_PROTOCOL, PROTO_ASC);
      gap_off;
      wr(A_PROTOCOL, PROTO_RTU);
      multidrop_i <= 1'b0;
      gap_off;
      $display("gap done");
   endtask : t_gap
   task t_ctl;
      wr(A_CTL_CODE, 16'h04D2);
      rd(A_CTL_CODE);
      chk(rdv === 16'h04D2, "plain code kept");
      foreach (bds[k]) if (k < 3) begin
         wr(A_CTL_CODE, CTL_LIST + 16'(k));
         rd(A_CTL_CODE);
         chk(rdv === 16'h0000, "control code stored");
      end
      rd(A_PAUSE);
      chk(rdv === 16'h0000, "cold restart kept config");
      $display("control done");
   endtask : t_ctl
   task end_of_test;
      $display("checks %0d errors %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : end_of_test
   initial begin
      repeat (2) @(posedge clk_i);
      rstn_i <= 1'b1;
      t_regs;
      t_poll;
      t_timeout;
      t_stall;
      t_noloc;
      t_gap;
      t_ctl;
      end_of_test;
   end
endmodule : tb_top
